// ### hdl/bsc_chain.sv
`timescale 1ns/100ps
module bsc_chain
  import bsc_pkg::*;
#(
  parameter logic [15:0] RESET_TIMEOUT = RST_TIMEOUT_N
) (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // tap pins
  input  wire logic                  tck_i,
  input  wire logic                  tms_i,
  input  wire logic                  tdi_i,
  output logic                       tdo_o,
  output logic                       tdo_oe_o,
  // port logic, already resolved after alternate functions
  input  wire logic                  global_pullup_disable_i,
  input  wire logic [NPINS-1:0]      direction_bit_i,
  input  wire logic [NPINS-1:0]      port_output_bit_i,
  // pad levels
  input  wire logic [NPINS-1:0]      pin_input_value_i,
  input  wire logic                  low_voltage_reset_observe_i,
  input  wire logic                  high_voltage_reset_observe_i,
  input  wire logic [NOSC-1:0]       osc_enable_i,
  input  wire logic [NOSC-1:0]       osc_clock_i,
  // pad drive
  output bsc_pin_drive_s [NPINS-1:0] pad_drive_o,
  output logic [NOSC-1:0]            osc_enable_o,
  // core reset request
  output logic                       core_reset_o
);
  bsc_tap_pins_s tap_sync;
  logic          tck_d_reg, tck_d_next;
  logic          rise, fall;
  bsc_tap_e      state_reg, state_next;
  logic [IR_W-1:0] ir_sh_reg, ir_sh_next, ir_reg, ir_next;
  logic [ID_W-1:0] id_sh_reg, id_sh_next;
  logic [CHAIN_W-1:0] bs_sh_reg, bs_sh_next, bs_up_reg, bs_up_next;
  logic          byp_reg, byp_next, rstbit_reg, rstbit_next;
  logic          tdo_reg, tdo_next, oe_reg, oe_next;
  logic [15:0]   tmo_reg, tmo_next;
  logic          core_rst_reg, core_rst_next;
  bsc_pin_drive_s [NPINS-1:0] drv_reg, drv_next;
  logic [NOSC-1:0] osc_en_reg, osc_en_next;
  logic [CHAIN_W-1:0] cap;
  logic [ID_W-1:0]    id_word;
  logic          sel_bs, sel_id, sel_rst, sel_byp, dr_out;

  // tck sampled like any pin; edges found on the core clock
  bsc_sync #(.W(3)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({tck_i, tms_i, tdi_i}),
    .sync_o     (tap_sync)
  );

  // previous synchronised tck level; reset low matches the idle pin, so no false edge
  always_comb begin
    tck_d_next = tap_sync.tck;
  end

  assign rise = tap_sync.tck & ~tck_d_reg;
  assign fall = ~tap_sync.tck & tck_d_reg;
  assign id_word = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

  // data register select; unassigned opcodes fall to bypass
  always_comb begin
    sel_bs  = (ir_reg == OP_EXTEST) || (ir_reg == OP_SAMPLE);
    sel_id  = (ir_reg == OP_IDCODE);
    sel_rst = (ir_reg == OP_CORE_RESET);
    sel_byp = !(sel_bs || sel_id || sel_rst);
  end

  // capture vector: real pad levels, resolved port logic
  always_comb begin
    cap = '0;
    for (int i = 0; i < NPINS; i++) begin
      // pullup = ~pud & ~dir & port
      cap[i*PIN_CELLS]     = ~global_pullup_disable_i & ~direction_bit_i[i] & port_output_bit_i[i];
      // three-stage pin cell: pullup, control, then data/input shared stage
      cap[i*PIN_CELLS + 1] = direction_bit_i[i];
      cap[i*PIN_CELLS + 2] = pin_input_value_i[i];
    end
    cap[RST_BASE]     = low_voltage_reset_observe_i;
    cap[RST_BASE + 1] = high_voltage_reset_observe_i;
    for (int k = 0; k < NOSC; k++) begin
      cap[OSC_BASE + 2*k]     = osc_enable_i[k];
      cap[OSC_BASE + 2*k + 1] = osc_clock_i[k];
    end
  end

  // tap state machine on tck rising edges
  always_comb begin
    state_next = state_reg;
    if (rise) begin
      case (state_reg)
        TEST_LOGIC_RESET: state_next = tap_sync.tms ? TEST_LOGIC_RESET : RUN_TEST_IDLE;
        RUN_TEST_IDLE:    state_next = tap_sync.tms ? SELECT_DR : RUN_TEST_IDLE;
        SELECT_DR:        state_next = tap_sync.tms ? SELECT_IR : CAPTURE_DR;
        CAPTURE_DR:       state_next = tap_sync.tms ? EXIT1_DR : SHIFT_DR;
        SHIFT_DR:         state_next = tap_sync.tms ? EXIT1_DR : SHIFT_DR;
        EXIT1_DR:         state_next = tap_sync.tms ? UPDATE_DR : PAUSE_DR;
        PAUSE_DR:         state_next = tap_sync.tms ? EXIT2_DR : PAUSE_DR;
        EXIT2_DR:         state_next = tap_sync.tms ? UPDATE_DR : SHIFT_DR;
        UPDATE_DR:        state_next = tap_sync.tms ? SELECT_DR : RUN_TEST_IDLE;
        SELECT_IR:        state_next = tap_sync.tms ? TEST_LOGIC_RESET : CAPTURE_IR;
        CAPTURE_IR:       state_next = tap_sync.tms ? EXIT1_IR : SHIFT_IR;
        SHIFT_IR:         state_next = tap_sync.tms ? EXIT1_IR : SHIFT_IR;
        EXIT1_IR:         state_next = tap_sync.tms ? UPDATE_IR : PAUSE_IR;
        PAUSE_IR:         state_next = tap_sync.tms ? EXIT2_IR : PAUSE_IR;
        EXIT2_IR:         state_next = tap_sync.tms ? UPDATE_IR : SHIFT_IR;
        UPDATE_IR:        state_next = tap_sync.tms ? SELECT_DR : RUN_TEST_IDLE;
        default:          state_next = TEST_LOGIC_RESET;
      endcase
    end
  end

  // instruction register; idcode whenever the tap is reset
  always_comb begin
    ir_sh_next = ir_sh_reg;
    ir_next    = ir_reg;
    if (rise) begin
      case (state_reg)
        TEST_LOGIC_RESET: ir_next = OP_IDCODE;
        CAPTURE_IR:       ir_sh_next = IR_CAPTURE;
        SHIFT_IR:         ir_sh_next = {tap_sync.tdi, ir_sh_reg[IR_W-1:1]};
        UPDATE_IR:        ir_next = ir_sh_reg;
        default:          ir_next = ir_reg;
      endcase
    end
  end

  // data registers: capture, shift, update per selection
  always_comb begin
    id_sh_next  = id_sh_reg;
    bs_sh_next  = bs_sh_reg;
    bs_up_next  = bs_up_reg;
    byp_next    = byp_reg;
    rstbit_next = rstbit_reg;
    if (rise) begin
      case (state_reg)
        CAPTURE_DR: begin
          if (sel_id) begin
            id_sh_next = id_word;
          end else if (sel_bs) begin
            bs_sh_next = cap;
          end else if (sel_byp) begin
            byp_next = 1'b0;
          end
          // core reset bit keeps its value here
        end
        SHIFT_DR: begin
          if (sel_id) begin
            id_sh_next = {tap_sync.tdi, id_sh_reg[ID_W-1:1]};
          end else if (sel_bs) begin
            bs_sh_next = {tap_sync.tdi, bs_sh_reg[CHAIN_W-1:1]};
          end else if (sel_rst) begin
            rstbit_next = tap_sync.tdi;
          end else begin
            byp_next = tap_sync.tdi;
          end
        end
        UPDATE_DR: begin
          if (sel_bs) begin
            bs_up_next = bs_sh_reg;
          end
        end
        default: bs_up_next = bs_up_reg;
      endcase
    end
  end

  // serial output changes on the falling tck edge
  always_comb begin
    if (state_reg == SHIFT_IR) begin
      dr_out = ir_sh_reg[0];
    end else if (sel_id) begin
      dr_out = id_sh_reg[0];
    end else if (sel_bs) begin
      dr_out = bs_sh_reg[0];
    end else if (sel_rst) begin
      dr_out = rstbit_reg;
    end else begin
      dr_out = byp_reg;
    end
    tdo_next = tdo_reg;
    oe_next  = oe_reg;
    if (fall) begin
      tdo_next = dr_out;
      oe_next  = (state_reg == SHIFT_DR) || (state_reg == SHIFT_IR);
    end
  end

  // pad drive: latches reach pins only under extest, from the moment it is loaded
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      if (ir_reg == OP_EXTEST) begin
        drv_next[i].pullup_enable  = bs_up_reg[i*PIN_CELLS];
        drv_next[i].output_control = bs_up_reg[i*PIN_CELLS + 1];
        drv_next[i].output_data    = bs_up_reg[i*PIN_CELLS + 2];
      end else begin
        drv_next[i].pullup_enable  = ~global_pullup_disable_i & ~direction_bit_i[i] & port_output_bit_i[i];
        drv_next[i].output_control = direction_bit_i[i];
        drv_next[i].output_data    = port_output_bit_i[i];
      end
    end
    for (int k = 0; k < NOSC; k++) begin
      osc_en_next[k] = (ir_reg == OP_EXTEST) ? bs_up_reg[OSC_BASE + 2*k] : osc_enable_i[k];
    end
  end

  // core reset: held while the bit is one, then the timeout runs
  always_comb begin
    tmo_next      = tmo_reg;
    core_rst_next = core_rst_reg;
    if (rstbit_reg) begin
      tmo_next      = RESET_TIMEOUT;
      core_rst_next = 1'b1;
    end else if (tmo_reg != 16'h0000) begin
      tmo_next      = tmo_reg - 16'h0001;
      core_rst_next = 1'b1;
    end else begin
      core_rst_next = 1'b0;
    end
  end

  // one register stage for everything above; the reset bit is not reset by the tap
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tck_d_reg    <= 1'b0;
      state_reg    <= TEST_LOGIC_RESET;
      ir_sh_reg    <= '0;
      ir_reg       <= OP_IDCODE;
      id_sh_reg    <= '0;
      bs_sh_reg    <= '0;
      bs_up_reg    <= '0;
      byp_reg      <= 1'b0;
      rstbit_reg   <= 1'b0;
      tdo_reg      <= 1'b0;
      oe_reg       <= 1'b0;
      tmo_reg      <= 16'h0000;
      core_rst_reg <= 1'b0;
      drv_reg      <= '0;
      osc_en_reg   <= '0;
    end else begin
      tck_d_reg    <= tck_d_next;
      state_reg    <= state_next;
      ir_sh_reg    <= ir_sh_next;
      ir_reg       <= ir_next;
      id_sh_reg    <= id_sh_next;
      bs_sh_reg    <= bs_sh_next;
      bs_up_reg    <= bs_up_next;
      byp_reg      <= byp_next;
      rstbit_reg   <= rstbit_next;
      tdo_reg      <= tdo_next;
      oe_reg       <= oe_next;
      tmo_reg      <= tmo_next;
      core_rst_reg <= core_rst_next;
      drv_reg      <= drv_next;
      osc_en_reg   <= osc_en_next;
    end
  end

  assign tdo_o        = tdo_reg;
  assign tdo_oe_o     = oe_reg;
  assign pad_drive_o  = drv_reg;
  assign osc_enable_o = osc_en_reg;
  assign core_reset_o = core_rst_reg;
endmodule

// ### hdl/bsc_pkg.sv
package bsc_pkg;

  // instruction register
  localparam int          IR_W          = 4;
  localparam logic [3:0]  OP_EXTEST     = 4'h0;
  localparam logic [3:0]  OP_IDCODE     = 4'h1;
  localparam logic [3:0]  OP_SAMPLE     = 4'h2;
  localparam logic [3:0]  OP_CORE_RESET = 4'hC;
  localparam logic [3:0]  OP_BYPASS     = 4'hF;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;

  // identification word layout
  localparam int          ID_W          = 32;
  localparam int          VER_W         = 4;
  localparam int          PART_W        = 16;
  localparam int          MFR_W         = 11;
  localparam logic [3:0]  ID_VERSION    = 4'h0;
  localparam logic [15:0] ID_PART       = 16'h1234;
  localparam logic [10:0] ID_MFR        = 11'h055;

  // chain geometry
  localparam int          NPINS         = 8;
  localparam int          NOSC          = 2;
  localparam int          PIN_CELLS     = 3;
  localparam int          CHAIN_W       = NPINS * PIN_CELLS + 2 + NOSC * 2;
  localparam int          RST_BASE      = NPINS * PIN_CELLS;
  localparam int          OSC_BASE      = RST_BASE + 2;

  // core reset hold time after release
  localparam int          CLK_MHZ       = 10;
  localparam int          RST_TIMEOUT_US = 65;
  localparam int          RST_TIMEOUT_CYC = RST_TIMEOUT_US * CLK_MHZ;
  localparam logic [15:0] RST_TIMEOUT_N = 16'(RST_TIMEOUT_CYC);

  typedef enum logic [3:0] {
    TEST_LOGIC_RESET, RUN_TEST_IDLE, SELECT_DR, CAPTURE_DR, SHIFT_DR, EXIT1_DR,
    PAUSE_DR, EXIT2_DR, UPDATE_DR, SELECT_IR, CAPTURE_IR, SHIFT_IR, EXIT1_IR,
    PAUSE_IR, EXIT2_IR, UPDATE_IR
  } bsc_tap_e;

  // port pin as seen by the chain
  typedef struct packed {
    logic pullup_enable;
    logic output_control;
    logic output_data;
  } bsc_pin_drive_s;

  // tap pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsc_tap_pins_s;

endpackage

// ### hdl/bsc_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for a group of pins
module bsc_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] sync_reg;
  logic [W-1:0] sync_next;

  // first stage feeds only the second
  always_comb begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule

// ### verif/bsc_chain_props.sv
`timescale 1ns/100ps
// pin-level checks on the boundary-scan block
module bsc_chain_props
  import bsc_pkg::*;
#(
  parameter logic [15:0] RESET_TIMEOUT = RST_TIMEOUT_N
) (
  // clock and reset
  input wire logic                       core_clk_i,
  input wire logic                       rst_n_i,
  // tap pins
  input wire logic                       tck_i,
  input wire logic                       tdo_o,
  input wire logic                       tdo_oe_o,
  // port logic and pads
  input wire logic                       global_pullup_disable_i,
  input wire logic [NPINS-1:0]           direction_bit_i,
  input wire logic [NPINS-1:0]           port_output_bit_i,
  input wire logic [NOSC-1:0]            osc_enable_i,
  input wire bsc_pin_drive_s [NPINS-1:0] pad_drive_o,
  input wire logic [NOSC-1:0]            osc_enable_o,
  input wire logic                       core_reset_o
);
  bsc_pin_drive_s [NPINS-1:0] exp_pad;
  logic                       quiet_reg;
  logic                       quiet_next;
  logic [15:0]                hi_reg;
  logic [15:0]                hi_next;

  // port-logic view of each pad; quiet means no scan yet, so the default opcode still rules
  always_comb begin
    for (int i = 0; i < NPINS; i++) begin
      exp_pad[i] = {~global_pullup_disable_i & ~direction_bit_i[i] & port_output_bit_i[i],
                    direction_bit_i[i], port_output_bit_i[i]};
    end
    quiet_next = quiet_reg & ~tdo_oe_o;
    hi_next    = core_reset_o ? hi_reg + 16'h1 : 16'h0;
  end

  // history registers, reset with the block: quiet set to one, high count cleared
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      quiet_reg <= 1'b1;
      hi_reg    <= 16'h0;
    end else begin
      quiet_reg <= quiet_next;
      hi_reg    <= hi_next;
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> !core_reset_o && !tdo_oe_o)
    else $error("outputs not cleared by reset");
  a_pad_follows_port: assert property (quiet_reg && $past(rst_n_i) |-> pad_drive_o == $past(exp_pad))
    else $error("pad drive differs from port logic");
  a_osc_follows_in: assert property (quiet_reg && $past(rst_n_i) |-> osc_enable_o == $past(osc_enable_i))
    else $error("oscillator enable not passed through");
  a_reset_needs_op: assert property (quiet_reg |-> !core_reset_o)
    else $error("core reset without scan");
  a_tdo_after_fall: assert property ($past(rst_n_i) && tdo_o != $past(tdo_o) |-> !$past(tck_i, 2))
    else $error("tdo moved outside tck low");
  a_oe_after_fall: assert property ($past(rst_n_i) && tdo_oe_o != $past(tdo_oe_o) |-> !$past(tck_i, 2))
    else $error("tdo enable moved outside tck low");
  a_reset_at_shift: assert property ($rose(core_reset_o) |-> tdo_oe_o)
    else $error("core reset rose outside a shift");
  a_reset_hold_time: assert property ($fell(core_reset_o) |-> hi_reg > RESET_TIMEOUT)
    else $error("core reset released too early");

  c_core_reset: cover property ($rose(core_reset_o));
  c_reset_end: cover property ($fell(core_reset_o));
  c_scan: cover property ($rose(tdo_oe_o));
endmodule

bind bsc_chain bsc_chain_props #(.RESET_TIMEOUT(RESET_TIMEOUT)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .tck_i(tck_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .global_pullup_disable_i(global_pullup_disable_i), .direction_bit_i(direction_bit_i),
  .port_output_bit_i(port_output_bit_i), .osc_enable_i(osc_enable_i), .pad_drive_o(pad_drive_o),
  .osc_enable_o(osc_enable_o), .core_reset_o(core_reset_o));

// ### verif/bsc_jtag_host.sv
`timescale 1ns/100ps
// external scan controller; tck rests low between frames
module bsc_jtag_host (
  // pacing clock
  input  wire logic core_clk_i,
  // tap pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  // idle levels at time zero
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // one 800 ns tck period; tdo read at the end of high, long after it settled
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge core_clk_i);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (3) @(posedge core_clk_i);
    tck_o <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    tdo = tdo_i;
    tck_o <= 1'b0;
  endtask

  // five ones reach test-logic-reset, then park in run-test-idle
  task automatic reset_tap();
    logic b;
    repeat (5) tick(1'b1, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
  endtask

  // from idle through capture, n shifts, update, back to idle; unused tdi toggles
  task automatic scan(input logic ir, input logic [63:0] din, input int n, output logic [63:0] dout);
    logic b;
    dout = '0;
    tick(1'b1, ~tdi_o, b);
    if (ir)
      tick(1'b1, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tick(1'b1, ~tdi_o, b);
    tick(1'b0, ~tdi_o, b);
  endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top;
  import bsc_pkg::*;
  typedef struct packed {logic global_pullup_disable; logic [7:0] dir, port, pu; logic [1:0] osc;} bsc_row_s;
  int                         cmp_count = 0;
  int                         miscompares = 0;
  logic                       core_clk = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       tck, tms, tdi, tdo, tdo_oe, core_rst;
  logic                       global_pullup_disable = 1'b0, lv_rst = 1'b1, hv_rst = 1'b0;
  logic [7:0]                 dir = 8'h00, port = 8'h00, pins = 8'h5A;
  logic [1:0]                 osc_en = 2'h0, osc_ck = 2'h1, osc_en_o;
  bsc_pin_drive_s [NPINS-1:0] pad;
  logic [3:0]                 ops [5] = '{4'hF, 4'h3, 4'h7, 4'hA, 4'hE};
  bsc_row_s                   rows [3] = '{'{1'b0, 8'h0F, 8'h3C, 8'h30, 2'h1},
                                           '{1'b1, 8'h00, 8'hFF, 8'h00, 2'h2},
                                           '{1'b0, 8'h00, 8'hA5, 8'hA5, 2'h3}};

  // short hold-off keeps the reset release visible within one frame
  bsc_chain #(.RESET_TIMEOUT(16'h0004)) u_dut (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .global_pullup_disable_i(global_pullup_disable), .direction_bit_i(dir), .port_output_bit_i(port),
    .pin_input_value_i(pins), .low_voltage_reset_observe_i(lv_rst), .high_voltage_reset_observe_i(hv_rst),
    .osc_enable_i(osc_en), .osc_clock_i(osc_ck), .pad_drive_o(pad), .osc_enable_o(osc_en_o),
    .core_reset_o(core_rst));
  bsc_jtag_host u_host (.core_clk_i(core_clk), .tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

  // 10 MHz core clock
  always #50 core_clk = ~core_clk;

  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  // pads are looked at mid-cycle, away from the edge that launches them
  task automatic chk_port(input logic [7:0] pu);
    @(negedge core_clk);
    for (int i = 0; i < NPINS; i++) `CHK(pad[i], {pu[i], dir[i], port[i]})
    @(posedge core_clk);
  endtask
  task automatic chk_ext(input logic [29:0] v);
    @(negedge core_clk);
    for (int i = 0; i < NPINS; i++) `CHK(pad[i], {v[3*i], v[3*i+1], v[3*i+2]})
    `CHK(osc_en_o, {v[28], v[26]})
    @(posedge core_clk);
  endtask
  task automatic chk_cap(input logic [63:0] d);
    for (int i = 0; i < NPINS; i++) `CHK(d[3*i+2], pins[i])
    `CHK(d[29:24], {osc_ck[1], osc_en[1], osc_ck[0], osc_en[0], hv_rst, lv_rst})
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 0.5 ms
  initial begin
    #1_000_000;
    miscompares++;
    close_out();
  end

  // main sequence
  initial begin
    logic [63:0] d;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    foreach (rows[r]) begin
      global_pullup_disable <= rows[r].global_pullup_disable;
      dir <= rows[r].dir;
      port <= rows[r].port;
      osc_en <= rows[r].osc;
      repeat (3) @(posedge core_clk);
      chk_port(rows[r].pu);
      `CHK(osc_en_o, rows[r].osc)
    end
    note("ports");
    u_host.reset_tap();
    u_host.scan(1'b0, 64'h0, ID_W, d);
    `CHK(d[31:0], {ID_VERSION, ID_PART, ID_MFR, 1'b1})
    `CHK(tdo_oe, 1'b0)
    foreach (ops[k]) begin
      u_host.scan(1'b1, 64'(ops[k]), IR_W, d);
      `CHK(d[3:0], IR_CAPTURE)
      u_host.scan(1'b0, 64'hB, 4, d);
      `CHK(d[3:0], 4'h6)
    end
    note("bypass");
    u_host.scan(1'b1, 64'(OP_SAMPLE), IR_W, d);
    u_host.scan(1'b0, 64'h2AB3C5D1, CHAIN_W, d);
    chk_cap(d);
    chk_port(8'hA5);
    pins <= 8'hC3;
    lv_rst <= 1'b0;
    hv_rst <= 1'b1;
    osc_ck <= 2'h2;
    u_host.scan(1'b1, 64'(OP_EXTEST), IR_W, d);
    chk_ext(30'h2AB3C5D1);
    u_host.scan(1'b0, 64'h154C3A2E, CHAIN_W, d);
    chk_cap(d);
    chk_ext(30'h154C3A2E);
    note("chain");
    u_host.scan(1'b1, 64'(OP_CORE_RESET), IR_W, d);
    u_host.scan(1'b0, 64'h1, 1, d);
    `CHK(core_rst, 1'b1)
    u_host.scan(1'b0, 64'h0, 1, d);
    `CHK(d[0], 1'b1)
    `CHK(core_rst, 1'b0)
    u_host.scan(1'b0, 64'h1, 1, d);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK(core_rst, 1'b0)
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    u_host.reset_tap();
    u_host.scan(1'b0, 64'h0, ID_W, d);
    `CHK(d[31:0], {ID_VERSION, ID_PART, ID_MFR, 1'b1})
    note("core reset");
    close_out();
  end
endmodule
